// File: src/tag_pw_pkg.sv
package tag_pw_pkg;
  // request command codes
  localparam logic [7:0] CMD_WRITE_PW   = 8'hb1;
  localparam logic [7:0] CMD_LOCK       = 8'hb2;
  localparam logic [7:0] CMD_PRESENT_PW = 8'hb3;
  localparam logic [7:0] CMD_FAST_READ  = 8'hc0;
  // error codes
  localparam logic [7:0] ERR_ADDR       = 8'h10;
  localparam logic [7:0] ERR_LOCKED_NOW = 8'h11;
  localparam logic [7:0] ERR_LOCKED     = 8'h12;
  localparam logic [7:0] ERR_UNPROG     = 8'h13;
  localparam logic [7:0] ERR_NOT_LOCKED = 8'h14;
  localparam logic [7:0] ERR_GENERIC    = 8'h0f;
  // response flags and request flag bits
  localparam logic [7:0] RSP_OK         = 8'h00;
  localparam logic [7:0] RSP_ERR        = 8'h01;
  localparam int         FLG_ADDRESSED  = 5;
  localparam int         FLG_OPTION     = 6;
  localparam int         FLG_PW_AREA    = 7;
  // request layout
  localparam logic [4:0] ARG_BASE       = 5'd3;
  localparam logic [4:0] UID_BYTES      = 5'd8;
  localparam int         RX_BYTES       = 18;
  localparam int         TX_BYTES       = 8;
  localparam logic [7:0] PW_SLOT_MAX    = 8'h03;
  localparam logic [7:0] BLOCK_COUNT    = 8'h40;
  // crc16, reflected, sent inverted low byte first
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE   = 16'hf0b8;
  // timing
  localparam int CLK_PERIOD_NS          = 40;
  localparam int NOMINAL_REPLY_DELAY_NS = 320900;
  localparam int NVM_PERIOD_NS          = 302000;
  localparam int NVM_PERIODS            = 18;
  localparam int NVM_CYCLE_TIME_NS      = NOMINAL_REPLY_DELAY_NS + NVM_PERIODS * NVM_PERIOD_NS;
  localparam int REPLY_CYCLES = (NOMINAL_REPLY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVM_CYCLES   = (NVM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_TIME_NS  = 37760;
  localparam int BIT_CYCLES   = BIT_TIME_NS / CLK_PERIOD_NS;
  // apb map
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_MEM_INDEX  = 8'h08;
  localparam logic [7:0] OFS_MEM_DATA   = 8'h0c;
  localparam logic [7:0] OFS_BLOCK_STAT = 8'h10;
  localparam logic [7:0] MFG_CODE       = 8'h5a; // arbitrary value
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b011,
    ST_SEND = 3'b100
  } state_e;
endpackage

// File: src/tag_password_cmd_handler.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
// Behaviour
// R1: password write stores 32-bit data in slot
// R2: selector 00h kill, 01h-03h passwords, else error
// R3: reader stays silent during password write
// R4: write response waits for nvm cycle end
// R5: reader relocks password after successful write
// R6: write clears slot protect status first
// R7: write errors 10h, 12h, 13h
// R8: lock request sets rights and locks block
// R9: flag bit 8 picks memory or password
// R10: protect bits 01/10 act as 11
// R11: reader silent during lock programming
// R12: lock errors 10h, 11h, 14h
// R13: present compares slot, mismatch gives generic error
// R14: reader silent during password comparison
// R15: good present opens linked blocks
// R16: fast read returns four data bytes
// R17: fast read answers at double rate
// R18: option flag adds locking status byte
// R19: status bit 0 shows block locked
// R20: bad crc frames are silently dropped
module tag_password_cmd_handler
  import tag_pw_pkg::*;
#(
  parameter int reply_cycles = REPLY_CYCLES,
  parameter int nvm_cycles   = NVM_CYCLES,
  parameter int bit_cycles   = BIT_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_clk,
  input  wire logic        link_data,
  input  wire logic        link_frame,
  output logic             tx_data,
  output logic             tx_active,
  output logic             tx_fast
);
  typedef struct packed {
    state_e                  state;
    logic [2:0]              clk_q, dat_q, frm_q;
    logic [RX_BYTES-1:0][7:0] rx_buf;
    logic [4:0]              rx_cnt;
    logic [2:0]              rx_bit;
    logic [7:0]              rx_shift;
    logic [15:0]             rx_crc;
    logic [TX_BYTES-1:0][7:0] tx_buf;
    logic [3:0]              tx_len, tx_idx;
    logic [2:0]              tx_bit;
    logic                    tx_data, tx_active, tx_fast;
    logic [31:0]             cnt;
    logic [63:0][31:0]       mem;
    logic [63:0][7:0]        prot;
    logic [63:0]             locked;
    logic [3:0][31:0]        pw;
    logic [3:0][7:0]         pw_prot;
    logic [3:0]              pw_lock, pw_open, pw_prog;
    logic                    enable;
    logic [5:0]              mem_idx;
    logic [7:0]              last_cmd, last_err, drops;
    logic [31:0]             prdata;
  } state_s;

  state_s s, n;

  // request fields, decoded from the receive buffer
  logic [7:0]  flags, cmd, arg0, arg1;
  logic [4:0]  p, need;
  logic [31:0] data;
  logic [1:0]  sel;
  logic [5:0]  blk;
  logic [7:0]  norm;
  logic        clk_rise, frm_fall, crc_ok, known, rd_blocked;

  assign flags = s.rx_buf[0];
  assign cmd   = s.rx_buf[1];
  assign p     = flags[FLG_ADDRESSED] ? ARG_BASE + UID_BYTES : ARG_BASE;
  assign arg0  = s.rx_buf[p];
  assign arg1  = s.rx_buf[p + 5'd1];
  assign data  = {s.rx_buf[p + 5'd4], s.rx_buf[p + 5'd3], s.rx_buf[p + 5'd2], s.rx_buf[p + 5'd1]};
  assign sel   = arg0[1:0];
  assign blk   = arg0[5:0];
  // rw protection pair of 01 or 10 is stored as 11
  assign norm  = {arg1[7:3], (arg1[2] | arg1[1]) ? 2'b11 : 2'b00, arg1[0]}; // [R10]
  assign clk_rise   = s.clk_q[1] & ~s.clk_q[2];
  assign frm_fall   = s.frm_q[2] & ~s.frm_q[1];
  assign crc_ok     = s.rx_crc == CRC_RESIDUE;
  assign rd_blocked = (s.prot[blk][2:1] == 2'b11) & ~s.pw_open[s.prot[blk][4:3]];
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & (paddr > OFS_BLOCK_STAT);
  assign prdata     = s.prdata;
  assign tx_data    = s.tx_data;
  assign tx_active  = s.tx_active;
  assign tx_fast    = s.tx_fast;

  // expected frame length and command recognition
  always_comb
  begin
    need  = 5'd0;
    known = 1'b1;
    case (cmd)
      CMD_WRITE_PW, CMD_PRESENT_PW: need = p + 5'd7;
      CMD_LOCK:                     need = p + 5'd4;
      CMD_FAST_READ:                need = p + 5'd3;
      default:                      known = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    logic [7:0]  err;
    logic [3:0]  len;
    logic [15:0] c;
    logic        fb;
    logic [7:0]  b;
    err = 8'h00;
    len = 4'd1;
    c   = CRC_INIT;
    fb  = 1'b0;
    b   = 8'h00;
    n   = s;
    // link pins pass two flops before use
    n.clk_q = {s.clk_q[1:0], link_clk};
    n.dat_q = {s.dat_q[1:0], link_data};
    n.frm_q = {s.frm_q[1:0], link_frame};
    case (s.state)
      ST_IDLE:
      begin
        if (s.frm_q[1] & s.enable)
        begin
          n.state  = ST_RECV;
          n.rx_cnt = 5'd0;
          n.rx_bit = 3'd0;
          n.rx_crc = CRC_INIT;
        end
      end
      ST_RECV:
      begin
        // bits arrive lsb first on link clock rising edges
        if (clk_rise & s.frm_q[1])
        begin
          fb         = s.rx_crc[0] ^ s.dat_q[1];
          n.rx_crc   = (s.rx_crc >> 1) ^ (fb ? CRC_POLY : 16'h0000);
          n.rx_shift = {s.dat_q[1], s.rx_shift[7:1]};
          n.rx_bit   = s.rx_bit + 3'd1;
          if (s.rx_bit == 3'd7 && s.rx_cnt < 5'(RX_BYTES))
          begin
            n.rx_buf[s.rx_cnt] = {s.dat_q[1], s.rx_shift[7:1]};
            n.rx_cnt           = s.rx_cnt + 5'd1;
          end
        end
        if (frm_fall)
        begin
          // bad crc, wrong length or foreign code: drop quietly
          if (crc_ok & known & (s.rx_cnt == need) & (s.rx_buf[2] == MFG_CODE)) // [R20]
            n.state = ST_EXEC;
          else
          begin
            n.state = ST_IDLE;
            n.drops = s.drops + 8'd1;
          end
        end
      end
      ST_EXEC:
      begin
        n.cnt     = 32'(reply_cycles);
        n.tx_fast = 1'b0;
        case (cmd)
          CMD_WRITE_PW:
          begin
            n.cnt = 32'(nvm_cycles);
            if (arg0 > PW_SLOT_MAX)
              err = ERR_ADDR; // [R2] [R7]
            else if (s.pw_lock[sel] & ~s.pw_open[sel])
              err = s.pw_prog[sel] ? ERR_LOCKED : ERR_UNPROG; // [R7]
            else
            begin
              n.pw_prot[sel] = 8'h00; // [R6]
              n.pw[sel]      = data; // [R1]
              n.pw_prog[sel] = 1'b1;
              n.pw_lock[sel] = 1'b0;
            end
          end
          CMD_LOCK:
          begin
            n.cnt = 32'(nvm_cycles);
            if (flags[FLG_PW_AREA]) // [R9]
            begin
              if (arg0 > PW_SLOT_MAX)
                err = ERR_ADDR; // [R12]
              else if (~arg1[0])
                err = ERR_NOT_LOCKED;
              else if (s.pw_lock[sel])
                err = ERR_LOCKED_NOW;
              else
              begin
                n.pw_lock[sel] = 1'b1;
                n.pw_prot[sel] = norm;
              end
            end
            else if (arg0 >= BLOCK_COUNT)
              err = ERR_ADDR; // [R12]
            else if (~arg1[0])
              err = ERR_NOT_LOCKED;
            else if (s.locked[blk])
              err = ERR_LOCKED_NOW;
            else
            begin
              n.locked[blk] = 1'b1; // [R8]
              n.prot[blk]   = norm; // [R10]
            end
          end
          CMD_PRESENT_PW:
          begin
            n.cnt = 32'(nvm_cycles);
            if (arg0 == 8'h00 || arg0 > PW_SLOT_MAX || s.pw[sel] != data)
              err = ERR_GENERIC; // [R13]
            else
              n.pw_open[sel] = 1'b1; // [R15]
          end
          default:
          begin
            n.tx_fast = 1'b1; // [R17]
            if (arg0 >= BLOCK_COUNT)
              err = ERR_ADDR;
            else if (rd_blocked)
              err = ERR_GENERIC;
            else if (flags[FLG_OPTION])
            begin
              n.tx_buf[1] = {s.prot[blk][7:1], s.locked[blk]}; // [R18] [R19]
              n.tx_buf[5:2] = s.mem[blk]; // [R16]
              len = 4'd6;
            end
            else
            begin
              n.tx_buf[4:1] = s.mem[blk]; // [R16]
              len = 4'd5;
            end
          end
        endcase
        n.tx_buf[0] = RSP_OK;
        if (err != 8'h00)
        begin
          n.tx_buf[0] = RSP_ERR;
          n.tx_buf[1] = err;
          len         = 4'd2;
        end
        // crc over the response bytes, appended inverted
        for (int i = 0; i < TX_BYTES - 2; i++)
        begin
          b = n.tx_buf[i];
          for (int k = 0; k < 8; k++)
          begin
            fb = c[0] ^ b[k];
            if (4'(i) < len)
              c = (c >> 1) ^ (fb ? CRC_POLY : 16'h0000);
          end
        end
        n.tx_buf[len]        = ~c[7:0];
        n.tx_buf[len + 4'd1] = ~c[15:8];
        n.tx_len             = len + 4'd2;
        n.last_cmd           = cmd;
        n.last_err           = err;
        n.state              = ST_WAIT;
      end
      ST_WAIT:
      begin
        // reply held back for the reply delay or the nvm cycle
        if (s.cnt <= 32'd1) // [R4]
        begin
          n.state     = ST_SEND;
          n.tx_active = 1'b1;
          n.tx_data   = s.tx_buf[0][0];
          n.tx_idx    = 4'd0;
          n.tx_bit    = 3'd0;
          n.cnt       = 32'(s.tx_fast ? bit_cycles / 2 : bit_cycles) - 32'd1;
        end
        else
          n.cnt = s.cnt - 32'd1;
      end
      ST_SEND:
      begin
        // one bit per bit period, half period in fast mode
        if (s.cnt != 32'd0)
          n.cnt = s.cnt - 32'd1;
        else if (s.tx_bit == 3'd7 && s.tx_idx == s.tx_len - 4'd1)
        begin
          n.state     = ST_IDLE;
          n.tx_active = 1'b0;
          n.tx_data   = 1'b0;
        end
        else
        begin
          n.tx_bit  = s.tx_bit + 3'd1;
          n.tx_idx  = (s.tx_bit == 3'd7) ? s.tx_idx + 4'd1 : s.tx_idx;
          n.tx_data = s.tx_buf[(s.tx_bit == 3'd7) ? s.tx_idx + 4'd1 : s.tx_idx][s.tx_bit + 3'd1];
          n.cnt     = 32'(s.tx_fast ? bit_cycles / 2 : bit_cycles) - 32'd1; // [R17]
        end
      end
      default: n.state = ST_IDLE;
    endcase
    // apb: read data latched in setup, writes in access
    if (psel & ~penable & ~pwrite)
    begin
      case (paddr)
        OFS_CTRL:       n.prdata = {31'd0, s.enable};
        OFS_STATUS:     n.prdata = {s.drops, s.last_err, s.last_cmd, 5'd0, s.state};
        OFS_MEM_INDEX:  n.prdata = {26'd0, s.mem_idx};
        OFS_MEM_DATA:   n.prdata = s.mem[s.mem_idx];
        OFS_BLOCK_STAT: n.prdata = {20'd0, s.pw_open, s.prot[s.mem_idx][7:1], s.locked[s.mem_idx]};
        default:        n.prdata = 32'd0;
      endcase
    end
    if (psel & penable & pwrite)
    begin
      case (paddr)
        OFS_CTRL:      n.enable           = pwdata[0];
        OFS_MEM_INDEX: n.mem_idx          = pwdata[5:0];
        OFS_MEM_DATA:  n.mem[s.mem_idx]   = pwdata;
        default:       n.enable           = n.enable;
      endcase
    end
  end

  // the single state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= n;
  end

  sequence s_exec(logic [7:0] code);
    s.state == ST_EXEC && cmd == code;
  endsequence

  property p_crc_drop;
    @(posedge pclk) disable iff (!presetn)
    (s.state == ST_RECV && frm_fall && !crc_ok) |=> s.state == ST_IDLE ##1 !s.tx_active;
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("bad crc frame executed"); // [R20]

  property p_pw_store;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_WRITE_PW) ##0 (arg0 <= PW_SLOT_MAX && !s.pw_lock[sel]) |=>
      s.pw[$past(sel)] == $past(data) && s.pw_prot[$past(sel)] == 8'h00;
  endproperty
  a_pw_store: assert property (p_pw_store) else $error("password not stored"); // [R1] [R6]

  property p_sel_err;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_WRITE_PW) ##0 arg0 > PW_SLOT_MAX |=> s.tx_buf[0] == RSP_ERR && s.tx_buf[1] == ERR_ADDR;
  endproperty
  a_sel_err: assert property (p_sel_err) else $error("bad selector not refused"); // [R2] [R7]

  property p_nvm_hold;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_WRITE_PW) |=> (!s.tx_active && s.state == ST_WAIT)[*8];
  endproperty
  a_nvm_hold: assert property (p_nvm_hold) else $error("write reply too early"); // [R4]

  property p_lock_mem;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_LOCK) ##0 (!flags[FLG_PW_AREA] && arg0 < BLOCK_COUNT && arg1[0] && !s.locked[blk]) |=>
      s.locked[$past(blk)] && s.prot[$past(blk)][2:1] != 2'b01 && s.prot[$past(blk)][2:1] != 2'b10;
  endproperty
  a_lock_mem: assert property (p_lock_mem) else $error("block lock not applied"); // [R8] [R10]

  property p_lock_area;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_LOCK) ##0 (flags[FLG_PW_AREA] && arg0 <= PW_SLOT_MAX && arg1[0]) |=> s.pw_lock[$past(sel)];
  endproperty
  a_lock_area: assert property (p_lock_area) else $error("password area not locked"); // [R9]

  property p_lock_twice;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_LOCK) ##0 (!flags[FLG_PW_AREA] && arg0 < BLOCK_COUNT && arg1[0] && s.locked[blk]) |=>
      s.tx_buf[1] == ERR_LOCKED_NOW;
  endproperty
  a_lock_twice: assert property (p_lock_twice) else $error("relock not refused"); // [R12]

  property p_present;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_PRESENT_PW) |=> (s.tx_buf[0] == RSP_ERR) == !s.pw_open[$past(sel)] || $past(s.pw_open[sel]);
  endproperty
  a_present: assert property (p_present) else $error("present result wrong"); // [R13] [R15]

  property p_fast_read;
    @(posedge pclk) disable iff (!presetn)
    s_exec(CMD_FAST_READ) ##0 (arg0 < BLOCK_COUNT && flags[FLG_OPTION] && !rd_blocked) |=>
      s.tx_fast && s.tx_buf[1][0] == $past(s.locked[blk]) && s.tx_buf[5:2] == $past(s.mem[blk]);
  endproperty
  a_fast_read: assert property (p_fast_read) else $error("fast read reply wrong"); // [R16] [R17] [R18] [R19]
endmodule

// File: tb/reader_model.sv
`timescale 1ns/10ps
module reader_model
  import tag_pw_pkg::*;
#(
  parameter int bit_cycles = 8
) (
  input  wire logic pclk,
  output logic      link_clk,
  output logic      link_data,
  output logic      link_frame,
  input  wire logic tx_data,
  input  wire logic tx_active,
  input  wire logic tx_fast
);
  logic [7:0] rsp[$];
  int         latency;

  // reflected crc over a byte queue
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // link idle: clock stands still
  initial
  begin
    link_clk = 1'b0;
    link_data = 1'b0;
    link_frame = 1'b0;
  end

  // one request frame, then capture of the answer
  task automatic transact(input logic [7:0] req[$], input bit bad_crc, input int bound);
    logic [15:0] c;
    logic [7:0]  acc;
    int          n;
    int          bits;
    c = ~crc16(req) ^ {15'h0000, bad_crc};
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    rsp.delete();
    latency = 0;
    bits = 0;
    acc = 8'h00;
    // pins move by nonblocking assignment, clear of the pclk sampling race
    link_frame <= 1'b1;
    #320;
    foreach (req[i])
      for (int b = 0; b < 8; b++)
      begin
        link_data <= req[i][b]; // lsb first
        #160 link_clk <= 1'b1;
        #160 link_clk <= 1'b0;
      end
    #160 link_frame <= 1'b0;
    link_data <= ~link_data; // released line shows no stale value
    // field kept free of modulation until the tag answers
    while (tx_active !== 1'b1 && latency < bound)
    begin
      @(negedge pclk);
      latency++;
    end
    if (tx_active === 1'b1)
    begin
      n = (tx_fast === 1'b1) ? bit_cycles / 2 : bit_cycles;
      repeat (n / 2) @(negedge pclk);
      while (tx_active === 1'b1 && bits < 400)
      begin
        acc = {tx_data, acc[7:1]};
        bits++;
        if (bits % 8 == 0)
          rsp.push_back(acc);
        repeat (n) @(negedge pclk);
      end
    end
  endtask
endmodule

// File: tb/tb_tag_password_cmd_handler.sv
`timescale 1ns/10ps
module tb_tag_password_cmd_handler
  import tag_pw_pkg::*;
;
  localparam int REPC = 20;
  localparam int NVMC = 60;
  localparam int BITC = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, d1;
  logic        er, link_clk, link_data, link_frame, tx_data, tx_active, tx_fast;
  int          failures = 0;
  int          samples_checked = 0;
  // reference state of the tag
  logic [31:0] mem[64] = '{default: 32'h0};
  logic [7:0]  prot[64] = '{default: 8'h00};
  bit          blk_lock[64];
  logic [31:0] pw[4] = '{default: 32'h0};
  logic [3:0]  pw_prog = 4'h0, pw_lock = 4'h0, pw_open = 4'h0;

  tag_password_cmd_handler #(.reply_cycles(REPC), .nvm_cycles(NVMC), .bit_cycles(BITC)) u_tag_password_cmd_handler (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .link_data(link_data), .link_frame(link_frame), .tx_data(tx_data), .tx_active(tx_active), .tx_fast(tx_fast));

  reader_model #(.bit_cycles(BITC)) u_reader_model (
    .pclk(pclk), .link_clk(link_clk), .link_data(link_data), .link_frame(link_frame),
    .tx_data(tx_data), .tx_active(tx_active), .tx_fast(tx_fast));

  // 25 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // apb transfer: setup, access until pready
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      summarize();
    end
    @(posedge pclk);
  endtask

  // one request over the link, compared with the reference
  task automatic req(input logic [7:0] f, c, a, p, input logic [31:0] d, input int kind = 0);
    logic [7:0] rq[$];
    logic [7:0] e[$];
    logic [7:0] err;
    bit         drop;
    rq = {f, c, (kind == 2) ? ~MFG_CODE : MFG_CODE};
    if (f[FLG_ADDRESSED])
      repeat (UID_BYTES) rq.push_back(8'($urandom));
    rq.push_back(a);
    if (c == CMD_WRITE_PW || c == CMD_PRESENT_PW)
      for (int i = 0; i < 4; i++)
        rq.push_back(d[8*i +: 8]);
    if (c == CMD_LOCK)
      rq.push_back(p);
    drop = kind != 0 || !(c inside {CMD_WRITE_PW, CMD_LOCK, CMD_PRESENT_PW, CMD_FAST_READ});
    err = 8'h00;
    e = {RSP_OK};
    if (!drop)
      case (c)
        CMD_WRITE_PW:
          if (a > PW_SLOT_MAX)
            err = ERR_ADDR;
          else if (pw_lock[a] && !pw_open[a])
            err = pw_prog[a] ? ERR_LOCKED : ERR_UNPROG;
          else
          begin
            pw[a] = d;
            pw_prog[a] = 1'b1;
            pw_lock[a] = 1'b0;
          end
        CMD_LOCK:
          if (a >= (f[FLG_PW_AREA] ? 8'h04 : BLOCK_COUNT))
            err = ERR_ADDR;
          else if (!p[0])
            err = ERR_NOT_LOCKED;
          else if (f[FLG_PW_AREA] ? pw_lock[a] : blk_lock[a])
            err = ERR_LOCKED_NOW;
          else if (f[FLG_PW_AREA])
            pw_lock[a] = 1'b1;
          else
          begin
            blk_lock[a] = 1'b1;
            // any rw pair other than 00 is kept as full protection
            prot[a] = (p[2:1] == 2'b00) ? p : (p | 8'h06);
          end
        CMD_PRESENT_PW:
          if (a == 8'h00 || a > PW_SLOT_MAX || pw[a] !== d)
            err = ERR_GENERIC;
          else
            pw_open[a] = 1'b1;
        default:
          if (a >= BLOCK_COUNT)
            err = ERR_ADDR;
          else if (prot[a][2:1] != 2'b00 && !pw_open[prot[a][4:3]])
            err = ERR_GENERIC;
          else
          begin
            if (f[FLG_OPTION])
              e.push_back({prot[a][7:1], blk_lock[a]});
            for (int i = 0; i < 4; i++)
              e.push_back(mem[a][8*i +: 8]);
          end
      endcase
    if (err != 8'h00)
      e = {RSP_ERR, err};
    u_reader_model.transact(rq, kind == 1, drop ? 300 : 5000);
    if (drop)
      check("silent", u_reader_model.rsp.size(), 0);
    else
    begin
      if (u_reader_model.rsp.size() == 0)
      begin
        failures++;
        summarize();
      end
      check("rsp_len", u_reader_model.rsp.size(), e.size() + 2);
      foreach (e[i])
        check("rsp_byte", u_reader_model.rsp[i], e[i]);
      check("rsp_crc", u_reader_model.crc16(u_reader_model.rsp), CRC_RESIDUE);
      check("tx_fast", tx_fast, c == CMD_FAST_READ);
      if (c != CMD_FAST_READ)
        check("nvm_wait", u_reader_model.latency >= NVMC, 1);
    end
    @(posedge pclk);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'hdadd43d1));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // registers, unmapped place, random block contents
    apb(0, OFS_CTRL, 0);
    check("ctrl_reset", q, 0);
    apb(0, 8'h14, 0);
    check("unmapped_err", er, 1);
    apb(1, OFS_CTRL, 1);
    for (int i = 0; i < 9; i++)
    begin
      d1 = $urandom;
      mem[i] = d1;
      apb(1, OFS_MEM_INDEX, i);
      apb(1, OFS_MEM_DATA, d1);
    end
    apb(0, OFS_MEM_DATA, 0);
    check("mem_data", q, mem[8]);
    // fast reads, plain, with status, addressed, out of range
    req(8'h02, CMD_FAST_READ, 3, 0, 0);
    req(8'h42, CMD_FAST_READ, 3, 0, 0);
    req(8'h22, CMD_FAST_READ, 5, 0, 0);
    req(8'h02, CMD_FAST_READ, 8'h40, 0, 0);
    // password write, present, relock
    d1 = $urandom;
    req(8'h02, CMD_WRITE_PW, 1, 0, d1);
    req(8'h02, CMD_WRITE_PW, 0, 0, $urandom);
    req(8'h02, CMD_WRITE_PW, 4, 0, $urandom);
    req(8'h02, CMD_PRESENT_PW, 1, 0, ~d1);
    req(8'h02, CMD_PRESENT_PW, 0, 0, 0);
    req(8'h02, CMD_PRESENT_PW, 1, 0, d1);
    req(8'h82, CMD_LOCK, 1, 8'h01, 0);
    req(8'h02, CMD_WRITE_PW, 3, 0, $urandom);
    req(8'h82, CMD_LOCK, 3, 8'h01, 0);
    req(8'h02, CMD_WRITE_PW, 3, 0, $urandom);
    req(8'h82, CMD_LOCK, 2, 8'h01, 0);
    req(8'h02, CMD_WRITE_PW, 2, 0, $urandom);
    req(8'h82, CMD_LOCK, 5, 8'h01, 0);
    // block locks and protect settings
    req(8'h02, CMD_LOCK, 6, 8'h13, 0);
    req(8'h02, CMD_LOCK, 6, 8'h13, 0);
    req(8'h02, CMD_LOCK, 7, 8'h10, 0);
    req(8'h02, CMD_LOCK, 8'h40, 8'h01, 0);
    req(8'h42, CMD_FAST_READ, 6, 0, 0);
    req(8'h02, CMD_LOCK, 7, 8'h01, 0);
    req(8'h42, CMD_FAST_READ, 7, 0, 0);
    req(8'h02, CMD_LOCK, 8, 8'h0f, 0);
    req(8'h42, CMD_FAST_READ, 8, 0, 0);
    apb(1, OFS_MEM_INDEX, 6);
    apb(0, OFS_BLOCK_STAT, 0);
    check("block_stat", q, {20'h0, pw_open, prot[6][7:1], blk_lock[6]});
    // corrupted frames and an unknown command are dropped and counted
    req(8'h02, CMD_FAST_READ, 3, 0, 0, 1);
    req(8'h02, CMD_FAST_READ, 3, 0, 0, 2);
    req(8'h02, 8'ha5, 3, 0, 0);
    apb(0, OFS_STATUS, 0);
    check("drops", q[31:24], 3);
    // random fast reads
    repeat (4)
      req({1'b0, 1'($urandom), 6'h02}, CMD_FAST_READ, 8'($urandom_range(0, 9)), 0, 0);
    summarize();
  end
endmodule
